// ### dcr_pkg.sv
package dcr_pkg;

   // byte addresses of the capability words
   localparam logic [11:0] MEMORY_SIZE_CAPS_OFS         = 12'h008;
   localparam logic [11:0] CORE_FEATURE_CAPS_OFS        = 12'h010;
   localparam logic [11:0] PERIPHERAL_PRESENCE_CAPS_OFS = 12'h014;

   // byte addresses of the masked control words
   localparam logic [11:0] SOFT_RESET_CTL0_OFS       = 12'h040;
   localparam logic [11:0] RUN_GATING_CTL0_OFS       = 12'h100;
   localparam logic [11:0] SLEEP_GATING_CTL0_OFS     = 12'h110;
   localparam logic [11:0] DEEPSLEEP_GATING_CTL0_OFS = 12'h120;

   // memory size word fields
   localparam int          SRAM_SIZE_LSB   = 16;
   localparam int          FLASH_SIZE_LSB  = 0;
   localparam logic [15:0] SRAM_SIZE_VAL   = 16'h001f;
   localparam logic [15:0] FLASH_SIZE_VAL  = 16'h000f;

   // core feature word fields
   localparam int         PWM_FLAG_BIT         = 20;
   localparam int         CONVERTER_FLAG_BIT   = 16;
   localparam int         MIN_SYS_DIV_LSB      = 12;
   localparam int         MAX_RATE_LSB         = 8;
   localparam int         MEM_PROT_FLAG_BIT    = 7;
   localparam int         TEMP_SENSOR_FLAG_BIT = 5;
   localparam int         PLL_FLAG_BIT         = 4;
   localparam int         WATCHDOG_FLAG_BIT    = 3;
   localparam int         TRACE_OUT_FLAG_BIT   = 2;
   localparam int         SERIAL_DBG_FLAG_BIT  = 1;
   localparam int         JTAG_FLAG_BIT        = 0;
   localparam logic [3:0] MIN_SYS_DIV_VAL      = 4'h3;
   localparam logic [3:0] MAX_RATE_VAL         = 4'h2;

   // peripheral presence word fields
   localparam int COMPARATOR_ZERO_FLAG_BIT   = 24;
   localparam int TIMER_TWO_FLAG_BIT         = 18;
   localparam int TIMER_ONE_FLAG_BIT         = 17;
   localparam int TIMER_ZERO_FLAG_BIT        = 16;
   localparam int I2C_FLAG_BIT               = 12;
   localparam int SYNC_SERIAL_FLAG_BIT       = 4;
   localparam int ASYNC_SERIAL_ONE_FLAG_BIT  = 1;
   localparam int ASYNC_SERIAL_ZERO_FLAG_BIT = 0;

   // converter speed setting inside the gating words
   localparam int SPEED_LSB = 8;

   // footnoted flags of the core word that pass into the gating words
   localparam logic [31:0] GATING_MASK = 32'h00110f0f;
   localparam logic [31:0] SPEED_MASK  = 32'h00000f00;

   // control words after reset
   localparam logic [31:0] CTL_RESET_VAL    = 32'h00000000;
   localparam logic [31:0] GATING_RESET_VAL = 32'h00000001;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### dcr_caps.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module dcr_caps
   import dcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // write address channel
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // write response channel
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // read address channel
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // read data channel
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // masked control words toward the clock and reset logic
   output logic [31:0]      run_gating_ctl0,
   output logic [31:0]      sleep_gating_ctl0,
   output logic [31:0]      deepsleep_gating_ctl0,
   output logic [31:0]      soft_reset_ctl0
);

   // fixed words; reserved positions tie to zero
   logic [31:0] memory_size_caps;
   logic [31:0] core_feature_caps;
   logic [31:0] peripheral_presence_caps;
   logic [31:0] soft_reset_mask;

   // each word starts from zero, so no reserved bit can ever read one
   always_comb begin
      memory_size_caps = 32'h00000000;
      memory_size_caps[SRAM_SIZE_LSB +: 16]  = SRAM_SIZE_VAL;
      memory_size_caps[FLASH_SIZE_LSB +: 16] = FLASH_SIZE_VAL;
   end

   always_comb begin
      core_feature_caps = 32'h00000000;
      core_feature_caps[PWM_FLAG_BIT]       = 1'b1;
      core_feature_caps[CONVERTER_FLAG_BIT] = 1'b1;
      core_feature_caps[MIN_SYS_DIV_LSB +: 4] = MIN_SYS_DIV_VAL;
      core_feature_caps[MAX_RATE_LSB +: 4]    = MAX_RATE_VAL;
      core_feature_caps[MEM_PROT_FLAG_BIT]    = 1'b1;
      core_feature_caps[TEMP_SENSOR_FLAG_BIT] = 1'b1;
      core_feature_caps[PLL_FLAG_BIT]         = 1'b1;
      core_feature_caps[WATCHDOG_FLAG_BIT]    = 1'b1;
      core_feature_caps[TRACE_OUT_FLAG_BIT]   = 1'b1;
      core_feature_caps[SERIAL_DBG_FLAG_BIT]  = 1'b1;
      core_feature_caps[JTAG_FLAG_BIT]        = 1'b1;
   end

   always_comb begin
      peripheral_presence_caps = 32'h00000000;
      peripheral_presence_caps[COMPARATOR_ZERO_FLAG_BIT]   = 1'b1;
      peripheral_presence_caps[TIMER_TWO_FLAG_BIT]         = 1'b1;
      peripheral_presence_caps[TIMER_ONE_FLAG_BIT]         = 1'b1;
      peripheral_presence_caps[TIMER_ZERO_FLAG_BIT]        = 1'b1;
      peripheral_presence_caps[I2C_FLAG_BIT]               = 1'b1;
      peripheral_presence_caps[SYNC_SERIAL_FLAG_BIT]       = 1'b1;
      peripheral_presence_caps[ASYNC_SERIAL_ONE_FLAG_BIT]  = 1'b1;
      peripheral_presence_caps[ASYNC_SERIAL_ZERO_FLAG_BIT] = 1'b1;
   end

   // only single-bit flags may gate resets, not the multi-bit fields
   // built from the live caps word, so a new flag set flows straight in
   assign soft_reset_mask = core_feature_caps
                          & ~(32'h0000000f << MIN_SYS_DIV_LSB)
                          & ~(32'h0000000f << MAX_RATE_LSB);

   // address decode, shared by the read and the write path
   // bits 1:0 are ignored, so a sub-word offset aliases onto its word
   function automatic logic addr_hit(input logic [11:0] a);
      case ({a[11:2], 2'b00})
         MEMORY_SIZE_CAPS_OFS,
         CORE_FEATURE_CAPS_OFS,
         PERIPHERAL_PRESENCE_CAPS_OFS,
         SOFT_RESET_CTL0_OFS,
         RUN_GATING_CTL0_OFS,
         SLEEP_GATING_CTL0_OFS,
         DEEPSLEEP_GATING_CTL0_OFS: addr_hit = 1'b1;
         default:                   addr_hit = 1'b0;
      endcase
   endfunction

   // merge write data into a word under the byte strobes
   // unstrobed lanes keep their stored bytes, as a partial write expects
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            lane_merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   // gating word filter: drop unflagged bits, clip the speed field
   // the speed field rides outside the flag mask so the clip can act on it
   function automatic logic [31:0] gate_filter(input logic [31:0] v,
                                               input logic [31:0] caps);
      logic [31:0] f;
      f = v & GATING_MASK & (caps | SPEED_MASK);
      if (f[SPEED_LSB +: 4] > caps[MAX_RATE_LSB +: 4]) begin
         f[SPEED_LSB +: 4] = caps[MAX_RATE_LSB +: 4];
      end
      gate_filter = f;
   endfunction

   // write path state
   logic        aw_have;
   logic        w_have;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_have;
   logic        next_w_have;
   logic [11:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic [31:0] next_run;
   logic [31:0] next_sleep;
   logic [31:0] next_deep;
   logic [31:0] next_srst;

   // address and data are taken in either order; one write at a time
   always_comb begin
      next_aw_have = aw_have;
      next_w_have  = w_have;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_run     = run_gating_ctl0;
      next_sleep   = sleep_gating_ctl0;
      next_deep    = deepsleep_gating_ctl0;
      next_srst    = soft_reset_ctl0;
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_have = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_have = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      // the store waits for both halves, so a lone address never writes
      if (aw_have && w_have && !s_axi_bvalid) begin
         next_aw_have = 1'b0;
         next_w_have  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = addr_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         // capability words have no write term at all
         case ({aw_addr[11:2], 2'b00})
            RUN_GATING_CTL0_OFS: begin
               next_run = gate_filter(lane_merge(run_gating_ctl0, w_data,
                          w_strb), core_feature_caps);
            end
            SLEEP_GATING_CTL0_OFS: begin
               next_sleep = gate_filter(lane_merge(sleep_gating_ctl0,
                            w_data, w_strb), core_feature_caps);
            end
            DEEPSLEEP_GATING_CTL0_OFS: begin
               next_deep = gate_filter(lane_merge(deepsleep_gating_ctl0,
                           w_data, w_strb), core_feature_caps);
            end
            SOFT_RESET_CTL0_OFS: begin
               next_srst = lane_merge(soft_reset_ctl0, w_data, w_strb)
                         & soft_reset_mask;
            end
            default: begin
               next_srst = soft_reset_ctl0;
            end
         endcase
      end
      next_awready = !next_aw_have && !next_bvalid;
      next_wready  = !next_w_have && !next_bvalid;
   end

   // write path registers
   // gating words leave reset with the first flagged clock already on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have               <= 1'b0;
         w_have                <= 1'b0;
         aw_addr               <= 12'h000;
         w_data                <= 32'h00000000;
         w_strb                <= 4'h0;
         s_axi_awready         <= 1'b0;
         s_axi_wready          <= 1'b0;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= RESP_OKAY;
         run_gating_ctl0       <= GATING_RESET_VAL;
         sleep_gating_ctl0     <= GATING_RESET_VAL;
         deepsleep_gating_ctl0 <= GATING_RESET_VAL;
         soft_reset_ctl0       <= CTL_RESET_VAL;
      end else begin
         aw_have               <= next_aw_have;
         w_have                <= next_w_have;
         aw_addr               <= next_aw_addr;
         w_data                <= next_w_data;
         w_strb                <= next_w_strb;
         s_axi_awready         <= next_awready;
         s_axi_wready          <= next_wready;
         s_axi_bvalid          <= next_bvalid;
         s_axi_bresp           <= next_bresp;
         run_gating_ctl0       <= next_run;
         sleep_gating_ctl0     <= next_sleep;
         deepsleep_gating_ctl0 <= next_deep;
         soft_reset_ctl0       <= next_srst;
      end
   end

   // read path state
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   // one read at a time; data registered one cycle after the address
   // a read in the cycle of a store returns the word before the store
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case ({s_axi_araddr[11:2], 2'b00})
            MEMORY_SIZE_CAPS_OFS:         next_rdata = memory_size_caps;
            CORE_FEATURE_CAPS_OFS:        next_rdata = core_feature_caps;
            PERIPHERAL_PRESENCE_CAPS_OFS: begin
               next_rdata = peripheral_presence_caps;
            end
            SOFT_RESET_CTL0_OFS:          next_rdata = soft_reset_ctl0;
            RUN_GATING_CTL0_OFS:          next_rdata = run_gating_ctl0;
            SLEEP_GATING_CTL0_OFS:        next_rdata = sleep_gating_ctl0;
            DEEPSLEEP_GATING_CTL0_OFS:    next_rdata = deepsleep_gating_ctl0;
            default:                      next_rdata = 32'h00000000;
         endcase
      end
      next_arready = !next_rvalid;
   end

   // read path registers
   // rdata holds its last value after the handshake; only rvalid counts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

endmodule

// ### dcr_caps_asserts.sv
`timescale 1ns/1ps
module dcr_chk
   import dcr_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // read channels
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // write response
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // masked control words
   input wire logic [31:0] run_gating_ctl0,
   input wire logic [31:0] sleep_gating_ctl0,
   input wire logic [31:0] deepsleep_gating_ctl0,
   input wire logic [31:0] soft_reset_ctl0
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // read address taken, and every bit set in any gating word
   logic        ar_hs;
   logic [31:0] gate_or;
   assign ar_hs   = s_axi_arvalid && s_axi_arready;
   assign gate_or = run_gating_ctl0 | sleep_gating_ctl0
                  | deepsleep_gating_ctl0;
   rd_answer_a: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not one cycle after address");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before taken");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   mem_word_a: assert property (
      ar_hs && s_axi_araddr == MEMORY_SIZE_CAPS_OFS
      |=> s_axi_rdata == 32'h001f000f && s_axi_rresp == RESP_OKAY)
      else $error("memory size word wrong");
   core_word_a: assert property (
      ar_hs && s_axi_araddr == CORE_FEATURE_CAPS_OFS
      |=> s_axi_rdata == 32'h001132bf && s_axi_rresp == RESP_OKAY)
      else $error("core feature word wrong");
   periph_word_a: assert property (
      ar_hs && s_axi_araddr == PERIPHERAL_PRESENCE_CAPS_OFS
      |=> s_axi_rdata == 32'h01071013 && s_axi_rresp == RESP_OKAY)
      else $error("peripheral word wrong");
   gate_mask_a: assert property ((gate_or & 32'hffeef0f0) == 32'h0)
      else $error("unflagged gating bit set");
   speed_clip_a: assert property (run_gating_ctl0[11:8] <= 4'h2 &&
      sleep_gating_ctl0[11:8] <= 4'h2 && deepsleep_gating_ctl0[11:8] <= 4'h2)
      else $error("converter speed above maximum");
   srst_mask_a: assert property ((soft_reset_ctl0 & 32'hffeeff40) == 32'h0)
      else $error("unflagged soft reset bit set");
endmodule

// ### tb_dcr_caps.sv
`timescale 1ns/1ps
module tb_dcr_caps
   import dcr_pkg::*;
;
   // one row: address, write data, expected read back, expected response
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
   } dcr_row_t;
   localparam dcr_row_t ROWS [8] = '{
      '{12'h008, 32'hffffffff, 32'h001f000f, RESP_OKAY},
      '{12'h010, 32'h00000000, 32'h001132bf, RESP_OKAY},
      '{12'h014, 32'h00000000, 32'h01071013, RESP_OKAY},
      '{12'h100, 32'hffffffff, 32'h0011020f, RESP_OKAY},
      '{12'h110, 32'h00000100, 32'h00000100, RESP_OKAY},
      '{12'h120, 32'hfffff0f0, 32'h00110000, RESP_OKAY},
      '{12'h040, 32'hffffffff, 32'h001100bf, RESP_OKAY},
      '{12'h00c, 32'hffffffff, 32'h00000000, RESP_SLVERR}};
   // bus master side, all quiet at time zero
   logic        clk = 1'h0, rst_n = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdat;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        awrdy, wrdy, bvalid, arrdy, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, run_g, slp_g, dsl_g, srst;
   int          n_fail = 0, n_compared = 0;
   dcr_caps u_dut (
      .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .run_gating_ctl0(run_g),
      .sleep_gating_ctl0(slp_g), .deepsleep_gating_ctl0(dsl_g),
      .soft_reset_ctl0(srst));
   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (n_fail == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ready held low two cycles so the slave must hold a read answer; bvalid rises no earlier than bready
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int t = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      forever begin
         @(posedge clk);
         t++;
         if (awvalid && awrdy) awvalid <= 1'h0;
         if (wvalid && wrdy) wvalid <= 1'h0;
         if (bready && bvalid) begin
            resp = bresp;
            break;
         end
         if (t >= 2) bready <= 1'h1;
      end
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      int t = 0;
      araddr <= a;
      arvalid <= 1'h1;
      forever begin
         @(posedge clk);
         t++;
         if (arvalid && arrdy) arvalid <= 1'h0;
         if (rready && rvalid) begin
            rdat = rdata;
            resp = rresp;
            break;
         end
         if (t >= 2) rready <= 1'h1;
      end
      rready <= 1'h0;
   endtask
   // watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      // ordinary writes then read-back, control words also seen at the ports
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d, 4'hf);
         chk({30'h0, resp}, {30'h0, ROWS[i].r});
         rd(ROWS[i].a);
         chk(rdat, ROWS[i].e);
         chk({30'h0, resp}, {30'h0, ROWS[i].r});
         case (ROWS[i].a)
            RUN_GATING_CTL0_OFS:       chk(run_g, ROWS[i].e);
            SLEEP_GATING_CTL0_OFS:     chk(slp_g, ROWS[i].e);
            DEEPSLEEP_GATING_CTL0_OFS: chk(dsl_g, ROWS[i].e);
            SOFT_RESET_CTL0_OFS:       chk(srst, ROWS[i].e);
            default: ;
         endcase
      end
      // second reset in mid-run returns the control words to their reset values, not the caps
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      chk(run_g | slp_g | dsl_g, GATING_RESET_VAL);
      chk(run_g & slp_g & dsl_g, GATING_RESET_VAL);
      chk(srst, CTL_RESET_VAL);
      chk({30'h0, bvalid, rvalid}, 32'h0);
      rst_n <= 1'h1;
      rd(CORE_FEATURE_CAPS_OFS);
      chk(rdat, 32'h001132bf);
      // single lanes merge; lane 1 carries an over-range speed that clips
      wr(RUN_GATING_CTL0_OFS, 32'hffffffff, 4'h2);
      chk(run_g, 32'h00000201);
      wr(RUN_GATING_CTL0_OFS, 32'hffffffff, 4'h4);
      chk(run_g, 32'h00110201);
      results();
   end
endmodule
// checker rides on the design, watching its ports only
bind dcr_caps dcr_chk u_chk (
   .clk(clk), .rst_n(rst_n), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .run_gating_ctl0(run_gating_ctl0),
   .sleep_gating_ctl0(sleep_gating_ctl0),
   .deepsleep_gating_ctl0(deepsleep_gating_ctl0),
   .soft_reset_ctl0(soft_reset_ctl0));
